// *** xsx_pkg.sv ***
// Constants, types and the operand arithmetic of the execution slice for
// subtract, nibble exchange, zero/bit skips, table lookups and XOR.
// Assumes a single 50 MHz clock and synchronous data/program memories.
// How it works
// - minus from work register: work = work + ~mem + 1, four flags updated
// - minus into memory: same sum written to memory, work register kept
// - immediate minus: work = work + ~imm + 1, four flags updated
// - in-place nibble exchange writes swapped byte back, flags untouched
// - nibble exchange to work: swapped memory byte into work register only
// - a true skip discards the prefetched instruction with one dummy cycle
// - test byte: skip when memory byte is zero, nothing written
// - move and test: copy byte to work, skip when zero, flags untouched
// - bit clear test: skip when selected bit is zero, flags untouched
// - bit set test: skip when selected bit is one, flags untouched
// - current page lookup: low byte to memory, high part to table high
// - last page lookup: same transfer from the last program page
// - XOR from memory into work register, only zero flag updated
// - XOR into memory, only zero flag updated
// - XOR immediate into work register, only zero flag updated
`timescale 1ns/1ps

package xsx_pkg;
  localparam int DATA_W = 8;
  localparam int ROM_W = 15;
  localparam int PAGE_W = 4;
  localparam int PADDR_W = 12;
  localparam int HIGH_W = 7;
  localparam logic [3:0] LAST_PAGE = 4'hF;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [6:0] HIGH_RESET = 7'h00;

  // instruction selects, binary coded because they arrive from a decoder
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_MINUS_WORK = 4'h1,
    OP_MINUS_INTO_MEMORY = 4'h2,
    OP_MINUS_IMM = 4'h3,
    OP_NIBBLE_EXCHANGE = 4'h4,
    OP_NIBBLE_EXCHANGE_TO_WORK = 4'h5,
    OP_TEST_BYTE_SKIP = 4'h6,
    OP_MOVE_TEST_SKIP = 4'h7,
    OP_BIT_CLEAR_SKIP = 4'h8,
    OP_BIT_SET_SKIP = 4'h9,
    OP_LOOKUP_CURRENT_PAGE = 4'hA,
    OP_LOOKUP_LAST_PAGE = 4'hB,
    OP_EXCLUSIVE_OR_WORK = 4'hC,
    OP_EXCLUSIVE_OR_INTO_MEMORY = 4'hD,
    OP_EXCLUSIVE_OR_IMM = 4'hE
  } xsx_op_type;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_EXEC = 5'h04,
    ST_ROM = 5'h08,
    ST_DUMMY = 5'h10
  } xsx_state_type;
endpackage : xsx_pkg

////////////////////////////////////////////////////////////////////////////
module xsx_alu
  import xsx_pkg::*;
(
  // operation and operands
  input wire xsx_op_type op_i,
  input wire logic [7:0] work_i,
  input wire logic [7:0] mem_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_sel_i,
  // results
  output logic [7:0] result_o,
  output logic zero_o,
  output logic carry_o,
  output logic nibble_carry_o,
  output logic signed_wrap_o,
  output logic arith_o,
  output logic logic_o,
  output logic write_work_o,
  output logic write_mem_o,
  output logic skip_o
);
  logic [7:0] operand;
  logic [8:0] diff;
  logic [4:0] low;

  // subtraction is done as addition of the inverted operand plus one
  always_comb
  begin
    operand = mem_i;
    if (op_i == OP_MINUS_IMM || op_i == OP_EXCLUSIVE_OR_IMM)
      operand = imm_i;
    diff = 9'({1'b0, work_i}) + 9'({1'b0, ~operand}) + 9'h001;
    low = 5'({1'b0, work_i[3:0]}) + 5'({1'b0, ~operand[3:0]}) + 5'h01;
    result_o = 8'h00;
    arith_o = 1'b0;
    logic_o = 1'b0;
    write_work_o = 1'b0;
    write_mem_o = 1'b0;
    skip_o = 1'b0;
    case (op_i)
      OP_MINUS_WORK, OP_MINUS_IMM:
      begin
        result_o = diff[7:0];
        arith_o = 1'b1;
        write_work_o = 1'b1;
      end
      OP_MINUS_INTO_MEMORY:
      begin
        result_o = diff[7:0];
        arith_o = 1'b1;
        write_mem_o = 1'b1;
      end
      OP_NIBBLE_EXCHANGE:
      begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        write_mem_o = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_WORK:
      begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        write_work_o = 1'b1;
      end
      OP_TEST_BYTE_SKIP:
        skip_o = (mem_i == 8'h00);
      OP_MOVE_TEST_SKIP:
      begin
        result_o = mem_i;
        write_work_o = 1'b1;
        skip_o = (mem_i == 8'h00);
      end
      OP_BIT_CLEAR_SKIP:
        skip_o = ~mem_i[bit_sel_i];
      OP_BIT_SET_SKIP:
        skip_o = mem_i[bit_sel_i];
      OP_EXCLUSIVE_OR_WORK, OP_EXCLUSIVE_OR_IMM:
      begin
        result_o = work_i ^ operand;
        logic_o = 1'b1;
        write_work_o = 1'b1;
      end
      OP_EXCLUSIVE_OR_INTO_MEMORY:
      begin
        result_o = work_i ^ operand;
        logic_o = 1'b1;
        write_mem_o = 1'b1;
      end
      default:
        result_o = 8'h00;
    endcase
    zero_o = (result_o == 8'h00);
    carry_o = diff[8];
    nibble_carry_o = low[4];
    // a signed wrap needs operands of unlike sign and a flipped sign bit
    signed_wrap_o = (work_i[7] != operand[7]) && (diff[7] != work_i[7]);
  end
endmodule // xsx_alu

// *** xsx_exec.sv ***
// Sequencer of the execution slice: fetches the operand, runs the
// arithmetic, writes back, drives table lookups and skip dummy cycles.
// Assumes data and program memories answer one clock after a read strobe.
`timescale 1ns/1ps

module xsx_exec
  import xsx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // instruction issue
  input wire logic start_i,
  input wire xsx_op_type op_i,
  input wire logic [7:0] addr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] imm_i,
  input wire logic [PAGE_W-1:0] pc_page_i,
  input wire logic [7:0] table_pointer_i,
  // data memory
  output logic [7:0] dmem_addr_o,
  output logic dmem_rd_o,
  output logic dmem_we_o,
  output logic [7:0] dmem_wdata_o,
  input wire logic [7:0] dmem_rdata_i,
  // program memory
  output logic [PADDR_W-1:0] rom_addr_o,
  output logic rom_rd_o,
  input wire logic [ROM_W-1:0] rom_data_i,
  // architectural state
  output logic [7:0] work_register_o,
  output logic zero_flag_o,
  output logic carry_flag_o,
  output logic nibble_carry_flag_o,
  output logic signed_wrap_flag_o,
  output logic [HIGH_W-1:0] table_high_byte_o,
  // sequencing status
  output logic ready_o,
  output logic done_o,
  output logic skip_o
);
  xsx_state_type state, next_state;
  xsx_op_type op, next_op;
  logic [2:0] bit_sel, next_bit_sel;
  logic [7:0] imm, next_imm;
  logic [7:0] next_dmem_addr, next_dmem_wdata, next_work;
  logic next_dmem_rd, next_dmem_we, next_rom_rd;
  logic [PADDR_W-1:0] next_rom_addr;
  logic next_zero, next_carry, next_nibble, next_wrap;
  logic [HIGH_W-1:0] next_high;
  logic next_ready, next_done, next_skip;
  logic [7:0] alu_result;
  logic alu_zero, alu_carry, alu_nibble, alu_wrap;
  logic alu_arith, alu_logic, alu_wwork, alu_wmem, alu_skip;
  logic is_lookup;

  ////////////////////////////////////////////////////////////////////////
  // operand arithmetic, fed from the latched instruction
  xsx_alu u_alu (
    .op_i(op),
    .work_i(work_register_o),
    .mem_i(dmem_rdata_i),
    .imm_i(imm),
    .bit_sel_i(bit_sel),
    .result_o(alu_result),
    .zero_o(alu_zero),
    .carry_o(alu_carry),
    .nibble_carry_o(alu_nibble),
    .signed_wrap_o(alu_wrap),
    .arith_o(alu_arith),
    .logic_o(alu_logic),
    .write_work_o(alu_wwork),
    .write_mem_o(alu_wmem),
    .skip_o(alu_skip)
  );

  assign is_lookup = (op == OP_LOOKUP_CURRENT_PAGE) ||
    (op == OP_LOOKUP_LAST_PAGE);

  ////////////////////////////////////////////////////////////////////////
  // next-state logic; every output is registered so strobes lag by a cycle
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_bit_sel = bit_sel;
    next_imm = imm;
    next_dmem_addr = dmem_addr_o;
    next_dmem_rd = 1'b0;
    next_dmem_we = 1'b0;
    next_dmem_wdata = dmem_wdata_o;
    next_rom_addr = rom_addr_o;
    next_rom_rd = 1'b0;
    next_work = work_register_o;
    next_zero = zero_flag_o;
    next_carry = carry_flag_o;
    next_nibble = nibble_carry_flag_o;
    next_wrap = signed_wrap_flag_o;
    next_high = table_high_byte_o;
    next_done = 1'b0;
    next_skip = 1'b0;
    unique case (state)
      ST_IDLE:
        if (start_i)
        begin
          next_op = op_i;
          next_bit_sel = bit_sel_i;
          next_imm = imm_i;
          next_dmem_addr = addr_i;
          if (op_i == OP_LOOKUP_CURRENT_PAGE)
          begin
            // pointer is only read, never advanced here
            next_rom_addr = {pc_page_i, table_pointer_i};
            next_rom_rd = 1'b1;
            next_state = ST_ROM;
          end
          else if (op_i == OP_LOOKUP_LAST_PAGE)
          begin
            next_rom_addr = {LAST_PAGE, table_pointer_i};
            next_rom_rd = 1'b1;
            next_state = ST_ROM;
          end
          else
          begin
            // immediates need no operand, but one path keeps timing uniform
            next_dmem_rd = 1'b1;
            next_state = ST_READ;
          end
        end
      ST_READ, ST_ROM:
        next_state = ST_EXEC;
      ST_EXEC:
      begin
        if (is_lookup)
        begin
          // low byte to memory, upper seven bits to the high register
          next_dmem_we = 1'b1;
          next_dmem_wdata = rom_data_i[7:0];
          next_high = rom_data_i[ROM_W-1:8];
        end
        else
        begin
          if (alu_wwork)
            next_work = alu_result;
          if (alu_wmem)
          begin
            next_dmem_we = 1'b1;
            next_dmem_wdata = alu_result;
          end
          if (alu_arith)
          begin
            next_zero = alu_zero;
            next_carry = alu_carry;
            next_nibble = alu_nibble;
            next_wrap = alu_wrap;
          end
          if (alu_logic)
            next_zero = alu_zero;
        end
        if (!is_lookup && alu_skip)
        begin
          // prefetched word is thrown away during the dummy cycle
          next_skip = 1'b1;
          next_state = ST_DUMMY;
        end
        else
        begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_DUMMY:
      begin
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      op <= OP_NONE;
      bit_sel <= 3'h0;
      imm <= 8'h00;
      dmem_addr_o <= 8'h00;
      dmem_rd_o <= 1'b0;
      dmem_we_o <= 1'b0;
      dmem_wdata_o <= 8'h00;
      rom_addr_o <= 12'h000;
      rom_rd_o <= 1'b0;
      work_register_o <= WORK_RESET;
      zero_flag_o <= 1'b0;
      carry_flag_o <= 1'b0;
      nibble_carry_flag_o <= 1'b0;
      signed_wrap_flag_o <= 1'b0;
      table_high_byte_o <= HIGH_RESET;
      ready_o <= 1'b1;
      done_o <= 1'b0;
      skip_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      bit_sel <= next_bit_sel;
      imm <= next_imm;
      dmem_addr_o <= next_dmem_addr;
      dmem_rd_o <= next_dmem_rd;
      dmem_we_o <= next_dmem_we;
      dmem_wdata_o <= next_dmem_wdata;
      rom_addr_o <= next_rom_addr;
      rom_rd_o <= next_rom_rd;
      work_register_o <= next_work;
      zero_flag_o <= next_zero;
      carry_flag_o <= next_carry;
      nibble_carry_flag_o <= next_nibble;
      signed_wrap_flag_o <= next_wrap;
      table_high_byte_o <= next_high;
      ready_o <= next_ready;
      done_o <= next_done;
      skip_o <= next_skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_minus_work;
    state == ST_EXEC && op == OP_MINUS_WORK |=> work_register_o ==
      8'($past(work_register_o) - $past(dmem_rdata_i)) &&
      signed_wrap_flag_o == ($past(work_register_o[7]) !=
      $past(dmem_rdata_i[7]) && work_register_o[7] !=
      $past(work_register_o[7]));
  endproperty
  a_minus_work: assert property (p_minus_work)
    else $error("minus to work wrong");

  property p_minus_mem;
    state == ST_EXEC && op == OP_MINUS_INTO_MEMORY |=> dmem_we_o &&
      dmem_wdata_o == 8'($past(work_register_o) - $past(dmem_rdata_i)) &&
      $stable(work_register_o);
  endproperty
  a_minus_mem: assert property (p_minus_mem)
    else $error("minus into memory wrong");

  property p_minus_imm;
    state == ST_EXEC && op == OP_MINUS_IMM |=> work_register_o ==
      8'($past(work_register_o) - $past(imm)) &&
      carry_flag_o == ($past(work_register_o) >= $past(imm));
  endproperty
  a_minus_imm: assert property (p_minus_imm)
    else $error("immediate minus wrong");

  property p_exchange;
    state == ST_EXEC && op == OP_NIBBLE_EXCHANGE |=> dmem_we_o &&
      dmem_wdata_o == {$past(dmem_rdata_i[3:0]), $past(dmem_rdata_i[7:4])}
      && $stable(carry_flag_o) && $stable(zero_flag_o);
  endproperty
  a_exchange: assert property (p_exchange)
    else $error("nibble exchange wrong");

  property p_exchange_work;
    state == ST_EXEC && op == OP_NIBBLE_EXCHANGE_TO_WORK |=> !dmem_we_o &&
      work_register_o == {$past(dmem_rdata_i[3:0]), $past(dmem_rdata_i[7:4])};
  endproperty
  a_exchange_work: assert property (p_exchange_work)
    else $error("exchange to work wrong");

  sequence s_dummy;
    skip_o && !ready_o ##1 done_o && ready_o && !skip_o;
  endsequence
  property p_skip;
    state == ST_EXEC && !is_lookup && alu_skip |=> s_dummy;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip lacks dummy cycle");

  property p_test_byte;
    state == ST_EXEC && op == OP_TEST_BYTE_SKIP |=>
      skip_o == ($past(dmem_rdata_i) == 8'h00) && !dmem_we_o;
  endproperty
  a_test_byte: assert property (p_test_byte)
    else $error("byte zero test wrong");

  property p_move_test;
    state == ST_EXEC && op == OP_MOVE_TEST_SKIP |=>
      work_register_o == $past(dmem_rdata_i) && $stable(zero_flag_o) &&
      skip_o == ($past(dmem_rdata_i) == 8'h00);
  endproperty
  a_move_test: assert property (p_move_test)
    else $error("move and test wrong");

  property p_bit_tests;
    state == ST_EXEC && (op == OP_BIT_CLEAR_SKIP || op == OP_BIT_SET_SKIP)
      |=> skip_o == ($past(dmem_rdata_i[bit_sel]) ==
      ($past(op) == OP_BIT_SET_SKIP)) && $stable(carry_flag_o);
  endproperty
  a_bit_tests: assert property (p_bit_tests)
    else $error("bit test wrong");

  sequence s_lookup;
    rom_rd_o && state == ST_ROM ##1 state == ST_EXEC ##1 done_o && dmem_we_o;
  endsequence
  property p_lookup;
    ready_o && start_i && (op_i == OP_LOOKUP_CURRENT_PAGE ||
      op_i == OP_LOOKUP_LAST_PAGE) |=> s_lookup;
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("lookup sequence wrong");

  property p_lookup_data;
    state == ST_EXEC && is_lookup |=> dmem_wdata_o == $past(rom_data_i[7:0])
      && table_high_byte_o == $past(rom_data_i[14:8]);
  endproperty
  a_lookup_data: assert property (p_lookup_data)
    else $error("lookup data wrong");

  property p_last_page;
    state == ST_ROM && op == OP_LOOKUP_LAST_PAGE |->
      rom_addr_o[PADDR_W-1:8] == LAST_PAGE;
  endproperty
  a_last_page: assert property (p_last_page)
    else $error("last page address wrong");

  property p_xor;
    state == ST_EXEC && (op == OP_EXCLUSIVE_OR_WORK ||
      op == OP_EXCLUSIVE_OR_INTO_MEMORY) |=> $stable(carry_flag_o) &&
      zero_flag_o == (($past(work_register_o) ^ $past(dmem_rdata_i)) == 8'h00);
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor zero flag wrong");

  property p_xor_imm;
    state == ST_EXEC && op == OP_EXCLUSIVE_OR_IMM |=> work_register_o ==
      ($past(work_register_o) ^ $past(imm)) && $stable(signed_wrap_flag_o);
  endproperty
  a_xor_imm: assert property (p_xor_imm)
    else $error("immediate xor wrong");
endmodule // xsx_exec

// *** xsx_mem_model.sv ***
// Far-side model: the data memory and program memory behind the slice.
// Assumes one-cycle read strobes, answered on the following clock edge.
`timescale 1ns/1ps

module xsx_mem_model
  import xsx_pkg::*;
(
  // clock
  input wire logic clk_i,
  // data memory side
  input wire logic [7:0] dmem_addr_i,
  input wire logic dmem_rd_i,
  input wire logic dmem_we_i,
  input wire logic [7:0] dmem_wdata_i,
  output logic [7:0] dmem_rdata_o,
  // program memory side
  input wire logic [PADDR_W-1:0] rom_addr_i,
  input wire logic rom_rd_i,
  output logic [ROM_W-1:0] rom_data_o
);
  logic [7:0] dmem [256];
  logic [ROM_W-1:0] rom [4096];

  ////////////////////////////////////////////////////////////////////////
  // memories; the testbench preloads and inspects them directly; read
  // data is valid only the cycle after a strobe, otherwise it is inverted
  // every cycle so a late sample can never look right by luck
  always @(posedge clk_i)
  begin
    if (dmem_we_i)
      dmem[dmem_addr_i] <= dmem_wdata_i;
    if (dmem_rd_i)
      dmem_rdata_o <= dmem[dmem_addr_i];
    else
      dmem_rdata_o <= ~dmem_rdata_o;
    if (rom_rd_i)
      rom_data_o <= rom[rom_addr_i];
    else
      rom_data_o <= ~rom_data_o;
  end
endmodule // xsx_mem_model

// *** xsx_exec_tb.sv ***
// Self-checking testbench of the execution slice: corner cases from a
// table, then random instructions; a shadow model predicts every result.
// Assumes xsx_pkg, xsx_exec and xsx_mem_model are compiled before it.
`timescale 1ns/1ps

module xsx_exec_tb;
  import xsx_pkg::*;

  logic clk_i, rst_i, start_i, dmem_rd_o, dmem_we_o, rom_rd_o;
  logic zero_flag_o, carry_flag_o, nibble_carry_flag_o, signed_wrap_flag_o;
  logic ready_o, done_o, skip_o;
  xsx_op_type op_i;
  logic [7:0] addr_i, imm_i, table_pointer_i, dmem_addr_o, dmem_wdata_o;
  logic [7:0] dmem_rdata_i, work_register_o;
  logic [2:0] bit_sel_i;
  logic [PAGE_W-1:0] pc_page_i;
  logic [PADDR_W-1:0] rom_addr_o;
  logic [ROM_W-1:0] rom_data_i;
  logic [HIGH_W-1:0] table_high_byte_o;
  // shadow of the architectural state
  logic [7:0] w_e;
  logic z_e, c_e, ac_e, ov_e;
  logic [6:0] tbh_e;
  // memory result of the previous instruction, checked once it has landed
  logic [7:0] prev_a, prev_x;
  logic prev_ok;
  int bad_count, n_tests;

  ////////////////////////////////////////////////////////////////////////
  xsx_exec xsx_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
    .op_i(op_i), .addr_i(addr_i), .bit_sel_i(bit_sel_i), .imm_i(imm_i),
    .pc_page_i(pc_page_i), .table_pointer_i(table_pointer_i),
    .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o), .dmem_we_o(dmem_we_o),
    .dmem_wdata_o(dmem_wdata_o), .dmem_rdata_i(dmem_rdata_i),
    .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o), .rom_data_i(rom_data_i),
    .work_register_o(work_register_o), .zero_flag_o(zero_flag_o),
    .carry_flag_o(carry_flag_o), .nibble_carry_flag_o(nibble_carry_flag_o),
    .signed_wrap_flag_o(signed_wrap_flag_o),
    .table_high_byte_o(table_high_byte_o), .ready_o(ready_o),
    .done_o(done_o), .skip_o(skip_o));

  xsx_mem_model xsx_mem_model_inst (.clk_i(clk_i), .dmem_addr_i(dmem_addr_o),
    .dmem_rd_i(dmem_rd_o), .dmem_we_i(dmem_we_o),
    .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i),
    .rom_addr_i(rom_addr_o), .rom_rd_i(rom_rd_o), .rom_data_o(rom_data_i));

  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // compare tasks, one per kind of result
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask

  // the one place where the run ends
  task automatic close_out();
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // predicts one instruction: updates the shadow, returns memory and skip
  function automatic void predict(input xsx_op_type op, input logic [7:0] m,
    input logic [7:0] imm, input logic [2:0] b, input logic [14:0] rw,
    output logic [7:0] mem_x, output logic sk);
    logic [7:0] v;
    logic [8:0] s;
    logic [4:0] h;
    mem_x = m;
    sk = 1'b0;
    v = (op == OP_MINUS_IMM || op == OP_EXCLUSIVE_OR_IMM) ? imm : m;
    case (op)
      OP_MINUS_WORK, OP_MINUS_INTO_MEMORY, OP_MINUS_IMM:
      begin
        s = {1'b0, w_e} + {1'b0, ~v} + 9'h001;
        h = {1'b0, w_e[3:0]} + {1'b0, ~v[3:0]} + 5'h01;
        ov_e = (w_e[7] == ~v[7]) && (s[7] != w_e[7]);
        c_e = s[8];
        ac_e = h[4];
        z_e = (s[7:0] == 8'h00);
        if (op == OP_MINUS_INTO_MEMORY)
          mem_x = s[7:0];
        else
          w_e = s[7:0];
      end
      OP_EXCLUSIVE_OR_WORK, OP_EXCLUSIVE_OR_INTO_MEMORY, OP_EXCLUSIVE_OR_IMM:
      begin
        z_e = ((w_e ^ v) == 8'h00);
        if (op == OP_EXCLUSIVE_OR_INTO_MEMORY)
          mem_x = w_e ^ v;
        else
          w_e = w_e ^ v;
      end
      OP_NIBBLE_EXCHANGE: mem_x = {m[3:0], m[7:4]};
      OP_NIBBLE_EXCHANGE_TO_WORK: w_e = {m[3:0], m[7:4]};
      OP_TEST_BYTE_SKIP: sk = (m == 8'h00);
      OP_MOVE_TEST_SKIP:
      begin
        w_e = m;
        sk = (m == 8'h00);
      end
      OP_BIT_CLEAR_SKIP: sk = ~m[b];
      OP_BIT_SET_SKIP: sk = m[b];
      OP_LOOKUP_CURRENT_PAGE, OP_LOOKUP_LAST_PAGE:
      begin
        mem_x = rw[7:0];
        tbh_e = rw[14:8];
      end
      default: sk = 1'b0;
    endcase
  endfunction

  // issues one instruction at a falling edge and checks everything after
  task automatic run_op(input xsx_op_type op, input logic [7:0] v,
    input logic [2:0] b);
    logic [7:0] a, tp, mem_x;
    logic [3:0] pg;
    logic [11:0] ra;
    logic sk, sk_seen;
    int n;
    // a fresh address, so the previous write cannot clobber this preload
    do
      a = 8'($urandom);
    while (prev_ok && a == prev_a);
    tp = 8'($urandom);
    pg = 4'($urandom);
    ra = (op == OP_LOOKUP_LAST_PAGE) ? {LAST_PAGE, tp} : {pg, tp};
    xsx_mem_model_inst.dmem[a] = v;
    predict(op, v, v, b, xsx_mem_model_inst.rom[ra], mem_x, sk);
    start_i = 1'b1;
    op_i = op;
    addr_i = a;
    imm_i = v;
    bit_sel_i = b;
    pc_page_i = pg;
    table_pointer_i = tp;
    @(negedge clk_i);
    start_i = 1'b0;
    op_i = xsx_op_type'(4'($urandom_range(0, 14)));
    // the write strobe comes with done, so memory changes one edge later
    if (prev_ok)
      chk_byte(xsx_mem_model_inst.dmem[prev_a], prev_x);
    n = 1;
    sk_seen = 1'b0;
    while (done_o !== 1'b1 && n < 8)
    begin
      sk_seen = sk_seen | (skip_o === 1'b1);
      @(negedge clk_i);
      n++;
    end
    chk_byte(8'(n), sk ? 8'h04 : 8'h03);
    chk_bit(sk_seen, sk);
    chk_byte(work_register_o, w_e);
    chk_byte({4'h0, zero_flag_o, carry_flag_o, nibble_carry_flag_o,
      signed_wrap_flag_o}, {4'h0, z_e, c_e, ac_e, ov_e});
    chk_byte({1'b0, table_high_byte_o}, {1'b0, tbh_e});
    chk_bit(ready_o, 1'b1);
    prev_a = a;
    prev_x = mem_x;
    prev_ok = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // corner cases, in an order where the work register value is known
  xsx_op_type c_op [18] = '{OP_EXCLUSIVE_OR_IMM, OP_MINUS_IMM,
    OP_EXCLUSIVE_OR_IMM, OP_MINUS_WORK, OP_MINUS_INTO_MEMORY,
    OP_TEST_BYTE_SKIP, OP_TEST_BYTE_SKIP, OP_MOVE_TEST_SKIP,
    OP_EXCLUSIVE_OR_IMM, OP_BIT_CLEAR_SKIP, OP_BIT_SET_SKIP, OP_BIT_SET_SKIP,
    OP_LOOKUP_LAST_PAGE, OP_LOOKUP_CURRENT_PAGE, OP_NIBBLE_EXCHANGE,
    OP_NIBBLE_EXCHANGE_TO_WORK, OP_EXCLUSIVE_OR_INTO_MEMORY, OP_NONE};
  logic [7:0] c_val [18] = '{8'hFF, 8'hFF, 8'h80, 8'h01, 8'hFF, 8'h00,
    8'h01, 8'h00, 8'h00, 8'hFE, 8'h80, 8'h7F, 8'h11, 8'h22, 8'hA5, 8'h3C,
    8'hC3, 8'h99};
  logic [2:0] c_bit [18] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};

  // main sequence; every input gets a value at time zero
  initial
  begin
    bad_count = 0;
    n_tests = 0;
    prev_ok = 1'b0;
    prev_a = 8'h00;
    prev_x = 8'h00;
    rst_i = 1'b1;
    start_i = 1'b0;
    op_i = OP_NONE;
    addr_i = 8'h00;
    imm_i = 8'h00;
    bit_sel_i = 3'h0;
    pc_page_i = 4'h0;
    table_pointer_i = 8'h00;
    void'($urandom(32'h37d3fc6e));
    for (int i = 0; i < 4096; i++)
      xsx_mem_model_inst.rom[i] = 15'($urandom);
    {w_e, z_e, c_e, ac_e, ov_e, tbh_e} = '0;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk_bit(ready_o, 1'b1);
    chk_byte(work_register_o, WORK_RESET);
    // back to back: each start after the first lands in the cycle that done is high
    for (int i = 0; i < 18; i++)
      run_op(c_op[i], c_val[i], c_bit[i]);
    for (int i = 0; i < 300; i++)
      run_op(xsx_op_type'(4'($urandom_range(0, 14))),
        ($urandom_range(0, 3) == 0) ? 8'h00 : 8'($urandom),
        3'($urandom));
    @(negedge clk_i);
    chk_byte(xsx_mem_model_inst.dmem[prev_a], prev_x);
    close_out();
  end

  // a hang is cut short well after the expected run length
  initial
  begin
    #(400 * 8 * 20 * 2);
    bad_count++;
    close_out();
  end
endmodule // xsx_exec_tb
